// >>> wwds_pkg.sv
`default_nettype none
package wwds_pkg;

  // ****************************************************************
  // Widths, the clock period in ns, and timing in clock cycles.
  // ****************************************************************
  localparam int unsigned WWDS_CNT_W        = 24;
  localparam int unsigned WWDS_CLK_PERIOD_NS = 100;
  localparam int unsigned WWDS_RST_DELAY_CYC = 200;
  localparam int unsigned WWDS_WDL_CYC      = 100;
  localparam int unsigned WWDS_WDU_EXT_CYC  = 1000;
  localparam int unsigned WWDS_WDU_PRE0_CYC = 1600;
  localparam int unsigned WWDS_WDU_PRE1_CYC = 2400;

  // ****************************************************************
  // Upper-bound selection codes.
  // ****************************************************************
  localparam logic [1:0] WWDS_SEL_EXT  = 2'h0;
  localparam logic [1:0] WWDS_SEL_PRE0 = 2'h1;
  localparam logic [1:0] WWDS_SEL_PRE1 = 2'h2;

  localparam logic [WWDS_CNT_W-1:0] WWDS_CNT_ZERO = '0;
  localparam logic [WWDS_CNT_W-1:0] WWDS_CNT_ONE  = {{(WWDS_CNT_W-1){1'b0}}, 1'b1};

  typedef enum logic [1:0] {
    WWDS_ST_RESET,
    WWDS_ST_RUN,
    WWDS_ST_FAULT
  } wwds_state_e;

  typedef struct packed {
    wwds_state_e             state;
    logic [WWDS_CNT_W-1:0]   rst_cnt;
    logic [WWDS_CNT_W-1:0]   win_cnt;
    logic [WWDS_CNT_W-1:0]   flt_cnt;
    logic                    kick_prev;
    logic                    rst_drv;
    logic                    flt_drv;
  } wwds_state_s;

endpackage
`default_nettype wire

// >>> wwds_top.sv
`timescale 1ns/10ps
`default_nettype none
module wwds_top
  import wwds_pkg::*;
#(
  parameter int unsigned RST_DELAY_CYC = WWDS_RST_DELAY_CYC,
  parameter int unsigned WDL_CYC       = WWDS_WDL_CYC,
  parameter int unsigned WDU_EXT_CYC   = WWDS_WDU_EXT_CYC,
  parameter int unsigned WDU_PRE0_CYC  = WWDS_WDU_PRE0_CYC,
  parameter int unsigned WDU_PRE1_CYC  = WWDS_WDU_PRE1_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       supply_ok,
  input  wire logic       manual_reset_n,
  input  wire logic       watchdog_enable_sel,
  input  wire logic       wd_kick_in,
  input  wire logic [1:0] timeout_select_in,
  output logic            sys_rst_out_n,
  output logic            sys_rst_drv_en,
  output logic            wd_fault_out_n,
  output logic            wd_fault_drv_en
);

  // ****************************************************************
  // Constants cut to the counter width.
  // ****************************************************************
  localparam logic [WWDS_CNT_W-1:0] RST_LAST = WWDS_CNT_W'(RST_DELAY_CYC - 1);
  localparam logic [WWDS_CNT_W-1:0] WDL_LIM  = WWDS_CNT_W'(WDL_CYC);

  wwds_state_s           st_reg;
  wwds_state_s           st_next;
  logic [WWDS_CNT_W-1:0] wdu_lim;
  logic                  hold_rst;
  logic                  kick_fall;

  // Upper bound follows the selection; unknown codes use the external one.
  always_comb begin
    case (timeout_select_in)
      WWDS_SEL_PRE0: wdu_lim = WWDS_CNT_W'(WDU_PRE0_CYC);
      WWDS_SEL_PRE1: wdu_lim = WWDS_CNT_W'(WDU_PRE1_CYC);
      default:       wdu_lim = WWDS_CNT_W'(WDU_EXT_CYC);
    endcase
  end

  // Either a low supply or a held manual reset keeps the output low.
  assign hold_rst  = !supply_ok || !manual_reset_n;
  assign kick_fall = st_reg.kick_prev && !wd_kick_in;

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  // The reset counter restarts on every hold so a glitchy supply never
  // shortens the delay; release happens only on a clean full count.
  always_comb begin
    st_next = st_reg;
    st_next.kick_prev = wd_kick_in;
    case (st_reg.state)
      WWDS_ST_RESET: begin
        st_next.rst_drv = 1'b1;
        st_next.flt_drv = 1'b0;
        st_next.win_cnt = WWDS_CNT_ZERO;
        if (hold_rst) begin
          st_next.rst_cnt = WWDS_CNT_ZERO;
        end else if (st_reg.rst_cnt == RST_LAST) begin
          st_next.rst_drv = 1'b0;
          st_next.state   = WWDS_ST_RUN;
        end else begin
          st_next.rst_cnt = st_reg.rst_cnt + WWDS_CNT_ONE;
        end
      end
      WWDS_ST_RUN: begin
        st_next.win_cnt = st_reg.win_cnt + WWDS_CNT_ONE;
        if (!watchdog_enable_sel) begin
          st_next.win_cnt = WWDS_CNT_ZERO;
        end else if (kick_fall) begin
          if (st_reg.win_cnt < WDL_LIM) begin
            st_next.state   = WWDS_ST_FAULT;
            st_next.flt_drv = 1'b1;
            st_next.flt_cnt = WWDS_CNT_ZERO;
          end else begin
            st_next.win_cnt = WWDS_CNT_ZERO;
          end
        end else if (st_reg.win_cnt >= wdu_lim - WWDS_CNT_ONE) begin
          st_next.state   = WWDS_ST_FAULT;
          st_next.flt_drv = 1'b1;
          st_next.flt_cnt = WWDS_CNT_ZERO;
        end
      end
      WWDS_ST_FAULT: begin
        // Kicks are not looked at here.
        st_next.flt_cnt = st_reg.flt_cnt + WWDS_CNT_ONE;
        if (st_reg.flt_cnt == RST_LAST) begin
          st_next.flt_drv = 1'b0;
          st_next.win_cnt = WWDS_CNT_ZERO;
          st_next.state   = WWDS_ST_RUN;
        end
      end
      default: begin
        st_next.state = WWDS_ST_RESET;
      end
    endcase
    // Supply or manual reset overrides everything, fault included.
    if (hold_rst) begin
      st_next.state   = WWDS_ST_RESET;
      st_next.rst_drv = 1'b1;
      st_next.flt_drv = 1'b0;
      st_next.rst_cnt = WWDS_CNT_ZERO;
      st_next.win_cnt = WWDS_CNT_ZERO;
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  // Reset starts with the reset output driven low, as on power-up.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{state: WWDS_ST_RESET, rst_cnt: WWDS_CNT_ZERO,
                  win_cnt: WWDS_CNT_ZERO, flt_cnt: WWDS_CNT_ZERO,
                  kick_prev: 1'b0, rst_drv: 1'b1, flt_drv: 1'b0};
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // Open-drain pins: enable high pulls the line low.
  assign sys_rst_drv_en  = st_reg.rst_drv;
  assign sys_rst_out_n   = !st_reg.rst_drv;
  assign wd_fault_drv_en = st_reg.flt_drv;
  assign wd_fault_out_n  = !st_reg.flt_drv;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  // Every check samples at the rising edge and is switched off while the
  // asynchronous reset is held, since the register is forced then.

  sequence s_fault_start;
    $rose(st_reg.flt_drv);
  endsequence

  sequence s_fault_hold;
    st_reg.flt_drv && !hold_rst;
  endsequence

  // Watchdog running, enabled and not overridden by a reset hold.
  sequence s_run_armed;
    clk_en && st_reg.state == WWDS_ST_RUN && watchdog_enable_sel
      && !hold_rst;
  endsequence

  // Release counter still short of its last value.
  sequence s_rst_counting;
    clk_en && st_reg.state == WWDS_ST_RESET && !hold_rst
      && st_reg.rst_cnt != RST_LAST;
  endsequence

  // Fault pulse still short of its full length.
  sequence s_flt_counting;
    clk_en && st_reg.state == WWDS_ST_FAULT && !hold_rst
      && st_reg.flt_cnt != RST_LAST;
  endsequence

  // The fault pin may only be pulled while the reset pin is free.
  a_fault_needs_run: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    wd_fault_drv_en |-> !sys_rst_drv_en)
    else $error("Fault asserted while reset low.");

  // A held reset leaves the fault pin undriven.
  a_fault_released_rst: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    sys_rst_drv_en |-> !wd_fault_drv_en)
    else $error("Fault driven during reset.");

  // A low supply pulls reset at the next enabled edge.
  a_low_supply_rst: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !supply_ok) |=> sys_rst_drv_en)
    else $error("Reset not asserted on low supply.");

  // A held manual reset pulls reset at the next enabled edge.
  a_manual_rst: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !manual_reset_n) |=> sys_rst_drv_en)
    else $error("Reset not asserted on manual reset.");

  // Release only at the last count of the delay.
  a_release_delay: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(sys_rst_drv_en) |-> st_reg.rst_cnt == RST_LAST)
    else $error("Reset released before delay done.");

  // Release only when both hold conditions were clear.
  a_release_cause: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(sys_rst_drv_en) |-> $past(supply_ok) && $past(manual_reset_n))
    else $error("Reset released while hold condition present.");

  // A fault pulse starts its length count from zero.
  a_fault_len: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_fault_start ##0 s_fault_hold) |->
      st_reg.flt_cnt == WWDS_CNT_ZERO)
    else $error("Fault pulse did not start from zero.");

  // A fault pulse ends on its own only after the full delay.
  a_fault_end: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(wd_fault_drv_en) && $past(st_reg.state) == WWDS_ST_FAULT
      && !$past(hold_rst) |-> $past(st_reg.flt_cnt) == RST_LAST)
    else $error("Fault pulse length wrong.");

  // A disabled watchdog never raises a fault.
  a_disabled_quiet: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !watchdog_enable_sel && st_reg.state == WWDS_ST_RUN)
      |=> !$rose(wd_fault_drv_en))
    else $error("Fault raised while watchdog disabled.");

  // A kick before the window opens is a fault.
  a_early_kick: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_run_armed ##0 (kick_fall && st_reg.win_cnt < WDL_LIM))
      |=> wd_fault_drv_en)
    else $error("Early kick did not fault.");

  // A kick inside the window restarts the window and raises nothing.
  a_kick_restart: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_run_armed ##0 (kick_fall && st_reg.win_cnt >= WDL_LIM))
      |=> st_reg.win_cnt == WWDS_CNT_ZERO && !wd_fault_drv_en)
    else $error("Accepted kick did not restart window.");

  // No kick by the upper bound is a timeout.
  a_late_fault: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_run_armed ##0 (!kick_fall && st_reg.win_cnt >= wdu_lim - WWDS_CNT_ONE))
      |=> wd_fault_drv_en)
    else $error("Missed kick did not fault.");

  // A low enable keeps every part of the state as it was.
  a_enable_freeze: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !clk_en |=> $stable(st_reg))
    else $error("State moved while clock enable low.");

  // Reset stays driven while the release count runs.
  a_rst_held_count: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_rst_counting |=> sys_rst_drv_en)
    else $error("Reset released during the delay count.");

  // The release count moves up by one per enabled edge.
  a_rst_counts_up: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_rst_counting |=>
      st_reg.rst_cnt == $past(st_reg.rst_cnt) + WWDS_CNT_ONE)
    else $error("Release count did not step by one.");

  // A hold throws away any partial release count.
  a_hold_clears_cnt: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && hold_rst) |=>
      st_reg.rst_cnt == WWDS_CNT_ZERO && st_reg.state == WWDS_ST_RESET)
    else $error("Hold did not restart the release count.");

  // A hold cuts a running fault pulse short.
  a_fault_cut_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && hold_rst) |=> !wd_fault_drv_en)
    else $error("Fault still driven after a hold.");

  // The window stays at zero while the watchdog is disabled.
  a_disabled_win_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !watchdog_enable_sel && st_reg.state == WWDS_ST_RUN
      && !hold_rst) |=> st_reg.win_cnt == WWDS_CNT_ZERO)
    else $error("Window moved while watchdog disabled.");

  // Kicks during a fault pulse do not end it before its full length.
  a_fault_ignores_kick: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_flt_counting |=> wd_fault_drv_en)
    else $error("Fault pulse ended early.");

  // The end of a fault pulse starts a fresh window.
  a_fault_restart_win: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && st_reg.state == WWDS_ST_FAULT && !hold_rst
      && st_reg.flt_cnt == RST_LAST)
      |=> !wd_fault_drv_en && st_reg.win_cnt == WWDS_CNT_ZERO)
    else $error("Fault end did not restart the window.");

  // Reset release starts a fresh window.
  a_release_win_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(sys_rst_drv_en) |-> st_reg.win_cnt == WWDS_CNT_ZERO)
    else $error("Window not at zero on reset release.");

  // Each pin level is the inverse of its drive enable.
  a_pin_pairs: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (sys_rst_out_n != sys_rst_drv_en) && (wd_fault_out_n != wd_fault_drv_en))
    else $error("Pin level and drive enable disagree.");

endmodule
`default_nettype wire

// >>> wwds_host.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Host model that kicks the watchdog.
// ****
module wwds_host (
  input  wire logic       clk_sys,
  input  wire logic [7:0] kick_at,
  input  wire logic       sys_rst_out_n,
  input  wire logic       wd_fault_out_n,
  output var logic        wd_kick_in = 1'b1
);
  logic [7:0] cnt_reg = 8'h00;
  // A kick is one low cycle; zero in kick_at models a hung host.
  always @(negedge clk_sys) begin
    wd_kick_in <= 1'b1;
    if (!sys_rst_out_n || !wd_fault_out_n) begin
      cnt_reg <= 8'h00;
    end else if (kick_at != 8'h00 && cnt_reg == kick_at) begin
      wd_kick_in <= 1'b0;
      cnt_reg    <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: check failed", $time); end end
module tb;
  import wwds_pkg::*;
  typedef struct packed {
    logic [1:0] sel;
    logic [7:0] kick;
    logic       flt;
  } wwds_row_s;
  localparam int D = 8;
  localparam wwds_row_s ROWS [6] = '{'{2'h0, 8'h0a, 1'b0},
    '{2'h0, 8'h02, 1'b1}, '{2'h1, 8'h19, 1'b0}, '{2'h2, 8'h23, 1'b0},
    '{2'h3, 8'h19, 1'b1}, '{2'h0, 8'h00, 1'b1}};
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       clk_en = 1'b1;
  logic       supply_ok = 1'b1;
  logic       mr_n = 1'b1;
  logic       en_sel = 1'b1;
  logic [1:0] sel = 2'h0;
  logic [7:0] kick_at = 8'h00;
  logic       kick, rst_o_n, rst_en, flt_n, flt_en, seen;
  int         tests_run = 0;
  int         n_mismatch = 0;
  int         n, w;
  // The bounds are small so each scenario stays a few dozen cycles long.
  wwds_top #(.RST_DELAY_CYC(D), .WDL_CYC(4), .WDU_EXT_CYC(20),
    .WDU_PRE0_CYC(30), .WDU_PRE1_CYC(40)) u_dut (.clk_sys(clk_sys),
    .rst_n(rst_n), .clk_en(clk_en), .supply_ok(supply_ok),
    .manual_reset_n(mr_n), .watchdog_enable_sel(en_sel),
    .wd_kick_in(kick), .timeout_select_in(sel), .sys_rst_out_n(rst_o_n),
    .sys_rst_drv_en(rst_en), .wd_fault_out_n(flt_n), .wd_fault_drv_en(flt_en));
  wwds_host u_host (.clk_sys(clk_sys), .kick_at(kick_at),
    .sys_rst_out_n(rst_o_n), .wd_fault_out_n(flt_n), .wd_kick_in(kick));
  // ****
  // Clock, waits and the verdict.
  // ****
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Counts edges until reset rises; a hang ends the run as a mismatch.
  task automatic wait_rst;
    n = 0;
    while (rst_o_n !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (n >= 100) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  task automatic restart(input logic [1:0] s, input logic [7:0] k);
    @(negedge clk_sys) mr_n = 1'b0;
    sel = s;
    kick_at = k;
    repeat (2) @(negedge clk_sys);
    mr_n = 1'b1;
    wait_rst();
  endtask
  // Returns the wait before a fault pulse in w and its width in n.
  task automatic flt_len;
    w = 0;
    n = 0;
    while (flt_n !== 1'b0 && w < 100) begin
      @(posedge clk_sys);
      #1 w++;
    end
    while (flt_n === 1'b0 && n < 100) begin
      `CHK(rst_o_n, 1'b1)
      `CHK(flt_en, 1'b1)
      @(posedge clk_sys);
      #1 n++;
    end
  endtask
  // ****
  // Table rows, then the awkward cases.
  // ****
  initial begin
    #500us n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (6) @(negedge clk_sys);
    `CHK({rst_o_n, flt_n}, 2'b01)
    rst_n = 1'b1;
    wait_rst();
    `CHK(n, D)
    foreach (ROWS[i]) begin
      restart(ROWS[i].sel, ROWS[i].kick);
      `CHK(n, D)
      seen = 1'b0;
      repeat (60) @(negedge clk_sys) seen |= (flt_n === 1'b0);
      `CHK(seen, ROWS[i].flt)
      $display("row %0d done", i);
    end
    restart(2'h0, 8'h00);
    flt_len();
    `CHK(w >= 18 && w <= 22, 1'b1)
    `CHK(n, D)
    flt_len();
    `CHK(w >= 18 && w <= 22, 1'b1)
    $display("fault pulse done");
    while (flt_n !== 1'b0) @(negedge clk_sys);
    supply_ok = 1'b0;
    @(posedge clk_sys);
    #1 `CHK({rst_o_n, rst_en, flt_n, flt_en}, 4'h6)
    @(negedge clk_sys) supply_ok = 1'b1;
    wait_rst();
    `CHK(n, D)
    $display("supply drop done");
    @(negedge clk_sys) en_sel = 1'b0;
    restart(2'h0, 8'h02);
    seen = 1'b0;
    repeat (60) @(negedge clk_sys) seen |= (flt_n === 1'b0);
    `CHK(seen, 1'b0)
    $display("disable done");
    @(negedge clk_sys) rst_n = 1'b0;
    en_sel = 1'b1;
    #1 `CHK({rst_o_n, flt_n}, 2'b01)
    @(negedge clk_sys) rst_n = 1'b1;
    clk_en = 1'b0;
    repeat (5) @(negedge clk_sys);
    `CHK(rst_o_n, 1'b0)
    clk_en = 1'b1;
    wait_rst();
    `CHK(n, D)
    $display("second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
